// File: core/pmux_port0.sv
// Purpose: Port 0 MII/RMII pin mux with strap capture
// Assumes: core_clk 10 MHz; link clock sampled as a plain input
// Notes:   Overview of operation list below
// Overview of operation
// - Decode three-bit strap into port mode
// - Modes 010/011: 200 Mbps, clock 12/16 mA from clk_strength_bit
// - Modes 100/101 drive 12/16 mA; 110 input
// - MAC mode: data bits carry transmit data pair
// - PHY mode: data bits carry receive data
// - RMII mode: data bits are receive pair
// - MAC mode: valid pin is transmit enable
// - PHY mode: valid pin is receive valid
// - RMII mode: valid pin is carrier/valid
// - Isolate disables data and valid drivers except in MAC mode
// - MAC mode: time outputs from PHY clock
// - PHY mode: drive clock, off when isolated
// - Mode bits 1:0 strapped on data pins
// - Mode bit 2 strapped; RMII bits 3:2 unused
`timescale 1ns/1ps
`default_nettype none
`include "pmux_defines.svh"
module pmux_port0 (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       strap_bit0_in,
  input  wire logic       strap_bit1_in,
  input  wire logic       strap_bit2_in,
  input  wire logic       virtual_phy_isolate_bit,
  input  wire logic       clk_strength_bit,
  input  wire logic       rmii_clk_dir_out,
  input  wire logic       port_clk_in,
  input  wire logic [1:0] core_data,
  input  wire logic       core_data_valid,
  output logic            port_out_data_bit1,
  output logic            port_out_data_bit0,
  output logic            port_out_data_bit1_oe,
  output logic            port_out_data_bit0_oe,
  output logic            port_out_data_valid,
  output logic            port_out_data_valid_oe,
  output logic            port_clk_out,
  output logic            port_clk_oe,
  output logic            port_clk_drive_16ma,
  output logic            turbo_rate,
  output logic            rmii_mode,
  output logic [2:0]      port_mode_strap_field
);
  typedef struct packed {
    logic                rst_meta;
    logic                rst_sync;
    logic                locked;
    logic [2:0]          mode;
    pmux_pkg::pmux_role_t role;
    logic [1:0]          dat;
    logic [1:0]          dat_oe;
    logic                dv;
    logic                dv_oe;
    logic                clk_out;
    logic                clk_oe;
    logic                drv16;
    logic                turbo;
    logic                rmii;
  } pmux_state_t;

  pmux_state_t st_q;
  pmux_state_t st_d;
  logic        rst_int_n;
  logic        lclk_rise;
  logic        iso_sync;
  logic        str_sync;
  logic        dir_sync;
  logic [2:0]  strap_raw;
  logic [2:0]  strap_sync;

  assign rst_int_n = st_q.rst_sync;
  assign strap_raw = {strap_bit2_in, strap_bit1_in, strap_bit0_in};

  // Link clock edges time the MAC-mode outputs
  pmux_sync u_lclk (
    .core_clk   (core_clk),
    .rst_n      (rst_int_n),
    .async_in   (port_clk_in),
    .sync_out   (),
    .rise_pulse (lclk_rise)
  );

  pmux_sync u_iso (
    .core_clk   (core_clk),
    .rst_n      (rst_int_n),
    .async_in   (virtual_phy_isolate_bit),
    .sync_out   (iso_sync),
    .rise_pulse ()
  );

  pmux_sync u_str (
    .core_clk   (core_clk),
    .rst_n      (rst_int_n),
    .async_in   (clk_strength_bit),
    .sync_out   (str_sync),
    .rise_pulse ()
  );

  pmux_sync u_dir (
    .core_clk   (core_clk),
    .rst_n      (rst_int_n),
    .async_in   (rmii_clk_dir_out),
    .sync_out   (dir_sync),
    .rise_pulse ()
  );

  // Strap stages never reset, so the strap is sampled while reset holds
  for (genvar k = 0; k < 3; k++) begin : g_strap
    pmux_sync u_strap (
      .core_clk   (core_clk),
      .rst_n      (1'b1),
      .async_in   (strap_raw[k]),
      .sync_out   (strap_sync[k]),
      .rise_pulse ()
    );
  end

  always_comb begin
    st_d          = st_q;
    st_d.rst_meta = 1'b1;
    st_d.rst_sync = st_q.rst_meta;
    if (!st_q.rst_sync) begin
      // Track straps while internal reset holds, drivers stay off
      st_d.mode   = strap_sync;
      st_d.locked = 1'b0;
      st_d.dat_oe = 2'b00;
      st_d.dv_oe  = 1'b0;
      st_d.clk_oe = 1'b0;
    end else begin
      st_d.locked = 1'b1;
      // Role decode of the latched strap
      case (st_q.mode)
        `PMUX_MODE_MAC:                       st_d.role = pmux_pkg::PMUX_ROLE_MAC;
        `PMUX_MODE_PHY:                       st_d.role = pmux_pkg::PMUX_ROLE_PHY;
        `PMUX_MODE_TURBO12, `PMUX_MODE_TURBO16: st_d.role = pmux_pkg::PMUX_ROLE_TURBO;
        `PMUX_MODE_RMII12, `PMUX_MODE_RMII16, `PMUX_MODE_RMIIIN:
                                              st_d.role = pmux_pkg::PMUX_ROLE_RMII;
        default:                              st_d.role = pmux_pkg::PMUX_ROLE_RSVD;
      endcase
      st_d.turbo = (st_d.role == pmux_pkg::PMUX_ROLE_TURBO);
      st_d.rmii  = (st_d.role == pmux_pkg::PMUX_ROLE_RMII);
      st_d.drv16 = 1'b0;
      st_d.clk_oe = 1'b0;
      st_d.clk_out = 1'b0;

      // Pin drive per role; made clock is core_clk/2 stand-in
      case (st_d.role)
        pmux_pkg::PMUX_ROLE_MAC: begin
          // Isolate ignored, pins always face the PHY
          st_d.dat_oe = 2'b11;
          st_d.dv_oe  = 1'b1;
          if (lclk_rise) begin
            st_d.dat = core_data;
            st_d.dv  = core_data_valid;
          end
        end
        pmux_pkg::PMUX_ROLE_PHY, pmux_pkg::PMUX_ROLE_TURBO: begin
          st_d.dat_oe  = {2{~iso_sync}};
          st_d.dv_oe   = ~iso_sync;
          st_d.clk_oe  = ~iso_sync;
          st_d.clk_out = ~st_q.clk_out;
          if (st_d.role == pmux_pkg::PMUX_ROLE_TURBO) begin
            st_d.drv16 = str_sync;
          end
          if (st_q.clk_out) begin
            st_d.dat = core_data;
            st_d.dv  = core_data_valid;
          end
        end
        pmux_pkg::PMUX_ROLE_RMII: begin
          st_d.dat_oe = {2{~iso_sync}};
          st_d.dv_oe  = ~iso_sync;
          if (st_q.mode == `PMUX_MODE_RMIIIN) begin
            st_d.clk_oe = 1'b0;
          end else begin
            st_d.clk_oe  = ~iso_sync & dir_sync;
            st_d.drv16   = (st_q.mode == `PMUX_MODE_RMII16);
            st_d.clk_out = ~st_q.clk_out;
          end
          st_d.dat = core_data;
          st_d.dv  = core_data_valid;
        end
        default: begin
          // Reserved code: every driver off
          st_d.dat_oe = 2'b00;
          st_d.dv_oe  = 1'b0;
          st_d.dat    = 2'b00;
          st_d.dv     = 1'b0;
        end
      endcase
    end
  end

  // Async reset; mode holds the strap default until sampled
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q      <= '0;
      st_q.mode <= `PMUX_STRAP_RST;
      st_q.role <= pmux_pkg::PMUX_ROLE_MAC;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from state flops
  assign port_out_data_bit1     = st_q.dat[1];
  assign port_out_data_bit0     = st_q.dat[0];
  assign port_out_data_bit1_oe  = st_q.dat_oe[1];
  assign port_out_data_bit0_oe  = st_q.dat_oe[0];
  assign port_out_data_valid    = st_q.dv;
  assign port_out_data_valid_oe = st_q.dv_oe;
  assign port_clk_out           = st_q.clk_out;
  assign port_clk_oe            = st_q.clk_oe;
  assign port_clk_drive_16ma    = st_q.drv16;
  assign turbo_rate             = st_q.turbo;
  assign rmii_mode              = st_q.rmii;
  assign port_mode_strap_field  = st_q.mode;
endmodule // pmux_port0
`default_nettype wire

// File: core/pmux_defines.svh
// Purpose: Constants for the port 0 pin mux
// Assumes: Included by its bare name
// Notes:   Strap codes are 3-bit mode encodings
`ifndef PMUX_DEFINES_SVH
`define PMUX_DEFINES_SVH
`define PMUX_MODE_MAC        3'h0
`define PMUX_MODE_PHY        3'h1
`define PMUX_MODE_TURBO12    3'h2
`define PMUX_MODE_TURBO16    3'h3
`define PMUX_MODE_RMII12     3'h4
`define PMUX_MODE_RMII16     3'h5
`define PMUX_MODE_RMIIIN     3'h6
`define PMUX_MODE_RSVD       3'h7
`define PMUX_STRAP_RST       3'h0
`define PMUX_CLK_DIV_W       1
`endif

// File: core/pmux_pkg.sv
// Purpose: Types for the port 0 pin mux
// Assumes: Nothing
// Notes:   Role decode of the strap
package pmux_pkg;
  typedef enum logic [2:0] {
    PMUX_ROLE_MAC,
    PMUX_ROLE_PHY,
    PMUX_ROLE_TURBO,
    PMUX_ROLE_RMII,
    PMUX_ROLE_RSVD
  } pmux_role_t;
endpackage

// File: core/pmux_sync.sv
// Purpose: Two-flop synchroniser with edge detect
// Assumes: Async active-low reset already synchronised
// Notes:   Edge detect compares the second stage with a third
`timescale 1ns/1ps
`default_nettype none
module pmux_sync (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      sync_out,
  output logic      rise_pulse
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } pmux_sync_state_t;

  pmux_sync_state_t st_q;
  pmux_sync_state_t st_d;

  always_comb begin
    st_d      = st_q;
    st_d.meta = async_in;
    st_d.sync = st_q.meta;
    st_d.prev = st_q.sync;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out   = st_q.sync;
  assign rise_pulse = st_q.sync & ~st_q.prev;
endmodule // pmux_sync
`default_nettype wire

// File: verif/pmux_far_phy.sv
// Purpose: External PHY model for port 0 MAC mode
// Assumes: Clock runs only while run is high
// Notes:   Captures transmit data on its own rising edge
`timescale 1ns/1ps
`default_nettype none
module pmux_far_phy (
  input  wire logic       run,
  input  wire logic [1:0] tx_data,
  output logic            tx_clk,
  output logic [1:0]      cap
);
  // Odd offset keeps the link clock out of phase with core_clk
  initial begin
    tx_clk = 1'b0;
    #37;
    forever #400 tx_clk = run ? ~tx_clk : 1'b0;
  end
  always @(posedge tx_clk) cap <= tx_data;
endmodule // pmux_far_phy
`default_nettype wire

// File: verif/pmux_port0_asserts.sv
// Purpose: Assertions on the port 0 pin mux
// Assumes: Bound to pmux_port0
// Notes:   Checks begin once the strap is locked
`timescale 1ns/1ps
`default_nettype none
module pmux_port0_chk (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       virtual_phy_isolate_bit,
  input wire logic [1:0] core_data,
  input wire logic       core_data_valid,
  input wire logic       port_out_data_bit1,
  input wire logic       port_out_data_bit0,
  input wire logic       port_out_data_valid,
  input wire logic       port_out_data_valid_oe,
  input wire logic       port_clk_out,
  input wire logic       port_clk_oe,
  input wire logic       port_clk_drive_16ma,
  input wire logic       turbo_rate,
  input wire logic       rmii_mode,
  input wire logic [2:0] port_mode_strap_field
);
  logic [2:0] up_q;
  logic       up, iso;
  logic [2:0] m;
  assign up  = up_q == 3'h7;
  assign iso = virtual_phy_isolate_bit;
  assign m   = port_mode_strap_field;
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n) up_q <= 3'h0;
    else if (!up) up_q <= up_q + 3'h1;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  AST_HOLD: assert property (up |-> $stable(m))
    else $error("mode moved");
  AST_TURBO: assert property (up |-> turbo_rate == (m[2:1] == 2'b01))
    else $error("rate flag");
  AST_RMII: assert property (up |-> rmii_mode == (m inside {3'h4, 3'h5, 3'h6}))
    else $error("rmii flag");
  AST_RSVD: assert property (up && m == 3'h7 |-> !port_out_data_valid_oe && !port_clk_oe)
    else $error("reserved drives");
  AST_MAC: assert property (up && m == 3'h0 |-> port_out_data_valid_oe && !port_clk_oe)
    else $error("mac enables");
  AST_ISO: assert property ((up && m inside {[3'h1:3'h6]} && iso)[*4] |-> !port_out_data_valid_oe && !port_clk_oe)
    else $error("isolate");
  AST_PHY_CLK: assert property ((up && m inside {[3'h1:3'h3]} && !iso)[*4] |-> port_clk_oe)
    else $error("phy clock off");
  AST_RMII_STR: assert property (up && m inside {3'h4, 3'h5} |-> port_clk_drive_16ma == m[0])
    else $error("rmii strength");
  AST_CLK_RUN: assert property (up && m inside {[3'h1:3'h5]} |=> port_clk_out != $past(port_clk_out))
    else $error("port clock stalled");
  AST_CLK_IDLE: assert property (up && m inside {3'h0, 3'h6, 3'h7} |-> !port_clk_out && !port_clk_drive_16ma)
    else $error("port clock driven");
  AST_RMII_DATA: assert property ((up && rmii_mode && !iso)[*4] |=>
    {port_out_data_bit1, port_out_data_bit0, port_out_data_valid} == $past({core_data, core_data_valid}))
    else $error("rmii data");
  AST_PHY_DATA: assert property ((up && m == 3'h1 && !iso)[*4] ##0 port_clk_out |=>
    {port_out_data_bit1, port_out_data_bit0, port_out_data_valid} == $past({core_data, core_data_valid}))
    else $error("phy data");
endmodule // pmux_port0_chk
bind pmux_port0 pmux_port0_chk u_chk (.*);
`default_nettype wire

// File: verif/pmux_port0_bench.sv
// Purpose: Self-checking bench for the port 0 pin mux
// Assumes: 10 MHz core clock, 800 ns link clock
// Notes:   Every strap code is run once
`timescale 1ns/1ps
`default_nettype none
module pmux_port0_bench;
  logic        core_clk = 1'b0, rst_n = 1'b0, iso = 1'b0, str = 1'b0, dir = 1'b0, dv = 1'b0, run = 1'b0;
  logic [2:0]  strap = 3'h0, fld;
  logic [1:0]  dat = 2'h0, cap;
  logic        b1, b0, b1oe, b0oe, v, voe, cko, coe, c16, tr, rm, lclk;
  logic [3:0]  e;
  logic [31:0] seed = 32'h0000_72d5, r;
  int          failures = 0, n_compared = 0, cyc = 0;
  always #50 core_clk = ~core_clk;
  pmux_port0 u_dut (.core_clk(core_clk), .rst_n(rst_n), .strap_bit0_in(strap[0]), .strap_bit1_in(strap[1]),
    .strap_bit2_in(strap[2]), .virtual_phy_isolate_bit(iso), .clk_strength_bit(str), .rmii_clk_dir_out(dir),
    .port_clk_in(lclk), .core_data(dat), .core_data_valid(dv), .port_out_data_bit1(b1), .port_out_data_bit0(b0),
    .port_out_data_bit1_oe(b1oe), .port_out_data_bit0_oe(b0oe), .port_out_data_valid(v),
    .port_out_data_valid_oe(voe), .port_clk_out(cko), .port_clk_oe(coe), .port_clk_drive_16ma(c16),
    .turbo_rate(tr), .rmii_mode(rm), .port_mode_strap_field(fld));
  pmux_far_phy u_phy (.run(run), .tx_data({b1, b0}), .tx_clk(lclk), .cap(cap));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // {data enables, clock enable, rate flag, rmii flag}
  function automatic logic [3:0] ex(input logic [2:0] m, input logic i, input logic d);
    return {m == 3'h0 || (m != 3'h7 && !i), !i && (m inside {[3'h1:3'h3]} || (m[2:1] == 2'b10 && d)),
      m[2:1] == 2'b01, m inside {[3'h4:3'h6]}};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [3:0] s, input logic [3:0] x);
    n_compared++;
    if (s !== x) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic complete_run();
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 6000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    for (int m = 0; m < 8; m++) begin
      rst_n = 1'b0;
      strap = m[2:0];
      tick(10);
      rst_n = 1'b1;
      tick(3);
      strap = ~strap; // Pins now carry data
      run = m == 0;
      tick(4);
      chk({1'b0, fld}, {1'b0, m[2:0]});
      for (int i = 0; i < 4; i++) begin
        r = xs();
        {dat, dv, str, dir} = r[4:0];
        iso = i == 3;
        tick(24);
        e = ex(m[2:0], iso, dir);
        chk({b1oe, b0oe, voe, coe}, {e[3], e[3], e[3], e[2]});
        chk({2'h0, tr, rm}, {2'h0, e[1:0]});
        if (!iso) chk({1'b0, b1, b0, v}, m == 7 ? 4'h0 : {1'b0, dat, dv});
        if (m == 0) chk({2'h0, cap}, {2'h0, dat});
        chk({3'h0, c16}, {3'h0, (m inside {[2:3]}) ? str : ((m inside {[4:5]}) ? m[0] : 1'b0)});
      end
      run = 1'b0;
    end
    complete_run();
  end
endmodule // pmux_port0_bench
`default_nettype wire
